// ### dfac_core_model.sv
`timescale 1ns/1ps
module dfac_core_model (
    // Clock
    input wire logic core_clk,
    // Wait-state setting
    output logic wsLoad,
    output logic [dfac_pkg::WS_W-1:0] wsIn,
    // Fetch port
    input wire logic fetchReady,
    input wire logic rdValid,
    output logic fetchReq,
    output logic [dfac_pkg::FETCH_ADDR_W-1:0] reqAddr
);
    import dfac_pkg::*;
    initial begin
        wsLoad = 1'b0;
        wsIn = 3'h4;
        fetchReq = 1'b0;
        reqAddr = '0;
    end
    // Loads a wait-state count for the 10 MHz system clock
    task automatic setWs(input logic [WS_W-1:0] ws);
        @(negedge core_clk);
        wsLoad = 1'b1;
        wsIn = (ws < 3'h2) ? 3'h2 : ws;
        @(negedge core_clk);
        wsLoad = 1'b0;
    endtask
    // Holds the request until taken, then counts falling edges to the answer
    task automatic fetch(input logic [FETCH_ADDR_W-1:0] a, output int lat);
        int n;
        n = 0;
        @(negedge core_clk);
        fetchReq = 1'b1;
        reqAddr = a;
        do begin
            @(posedge core_clk);
            n++;
        end while (fetchReady !== 1'b1 && n < 2000);
        lat = 0;
        do begin
            @(negedge core_clk);
            fetchReq = 1'b0;
            reqAddr = ~a;
            lat++;
        end while (rdValid !== 1'b1 && lat < 2000);
    endtask
endmodule

// ### dfac_flash_bank.sv
`timescale 1ns/1ps
module dfac_flash_bank #(
    parameter int AW = dfac_pkg::BANK_ADDR_W,
    parameter int DW = dfac_pkg::DATA_W,
    parameter int PIW = dfac_pkg::PAGE_IDX_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Read port
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData,
    // Write, mark and erase
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    input wire logic markEn,
    input wire logic eraseEn,
    input wire logic [AW-PIW-1:0] opPage
);
    import dfac_pkg::*;

    logic [DW-1:0] mem [1 << AW];
    logic [(1 << (AW-PIW))-1:0] pageWritten;
    logic [(1 << (AW-PIW))-1:0] next_pageWritten;

    // Unwritten pages read as erased
    always_comb begin
        rdData = pageWritten[rdAddr[AW-1:PIW]] ? mem[rdAddr] : ERASED_WORD;
    end

    always_comb begin
        next_pageWritten = pageWritten;
        if (eraseEn) begin
            next_pageWritten[opPage] = 1'b0;
        end
        if (markEn) begin
            next_pageWritten[opPage] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pageWritten <= '0;
        end else if (clkEn) begin
            pageWritten <= next_pageWritten;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clkEn && wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    a_erase_reads_ones: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && eraseEn && !markEn |=> !pageWritten[$past(opPage)])
        else $error("Erased page still marked written");
endmodule

// ### dfac_flash_ctrl.sv
`timescale 1ns/1ps
module dfac_flash_ctrl #(
    parameter int ERASE_CYCLES = dfac_pkg::ERASE_CYCLES,
    parameter int PROG_CYCLES = dfac_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Wait-state setting of the memory bus control
    input wire logic wsLoad,
    input wire logic [dfac_pkg::WS_W-1:0] wsIn,
    output logic [dfac_pkg::WS_W-1:0] waitStates,
    // Fetch port of the internal memory bus
    input wire logic fetchReq,
    input wire logic [dfac_pkg::FETCH_ADDR_W-1:0] reqAddr,
    input wire logic execFromSram,
    output logic fetchReady,
    output logic rdValid,
    output logic [dfac_pkg::DATA_W-1:0] rdData,
    // Page buffer load
    input wire logic loadEn,
    input wire logic [dfac_pkg::PAGE_IDX_W-1:0] loadIdx,
    input wire logic [dfac_pkg::DATA_W-1:0] loadData,
    // Program and erase commands
    input wire logic peReq,
    input wire logic peModule,
    input wire logic peOp,
    input wire logic [dfac_pkg::PAGE_NUM_W-1:0] pePage,
    output wire logic [dfac_pkg::NUM_MODULES-1:0] peBusy,
    output wire logic [dfac_pkg::NUM_MODULES-1:0] peDone,
    output logic peError
);
    import dfac_pkg::*;

    localparam int MAX_T = (ERASE_CYCLES > PROG_CYCLES) ? ERASE_CYCLES : PROG_CYCLES;
    localparam int CNT_W = $clog2(MAX_T + OVERHEAD_CYCLES + 1);
    localparam int MSB = FETCH_ADDR_W - 1;

    // Fetch engine state
    logic [FETCH_ADDR_W-1:0] engAddr, next_engAddr;
    logic [WS_W-1:0] engCnt, next_engCnt;
    logic engBusy, next_engBusy;
    logic demand, next_demand;
    logic pfValid, next_pfValid;
    logic [FETCH_ADDR_W-1:0] pfAddr, next_pfAddr;
    logic [DATA_W-1:0] pfData, next_pfData;
    logic activeModule, next_activeModule;
    logic activeValid, next_activeValid;
    logic [WS_W-1:0] next_waitStates;
    logic next_fetchReady, next_rdValid, next_peError;
    logic [DATA_W-1:0] next_rdData;
    logic accept, engDone, startFetch, readingFlash, refuse;
    logic [DATA_W-1:0] readData;
    logic [DATA_W-1:0] pageBuf [PAGE_WORDS];
    wire [NUM_MODULES-1:0] peActive;
    wire [DATA_W-1:0] bankRd [NUM_MODULES];

    assign readingFlash = activeValid && !execFromSram;
    assign accept = fetchReq && fetchReady;
    assign readData = bankRd[engAddr[MSB]];
    // A read of a module under erase or program holds until it is free
    assign engDone = engBusy && engCnt == '0 && !peActive[engAddr[MSB]];

    always_comb begin
        next_engAddr = engAddr;
        next_engCnt = engCnt;
        next_engBusy = engBusy;
        next_demand = demand;
        next_pfValid = pfValid;
        next_pfAddr = pfAddr;
        next_pfData = pfData;
        next_activeModule = activeModule;
        next_activeValid = activeValid;
        next_rdValid = 1'b0;
        next_rdData = rdData;
        next_waitStates = wsLoad ? wsIn : waitStates;
        startFetch = 1'b0;
        if (engDone) begin
            if (demand) begin
                // Answer and run ahead to the next word
                next_rdValid = 1'b1;
                next_rdData = readData;
                next_engAddr = engAddr + 1'b1;
                next_engCnt = waitStates;
                next_demand = 1'b0;
                startFetch = 1'b1;
            end else begin
                next_pfValid = 1'b1;
                next_pfAddr = engAddr;
                next_pfData = readData;
                next_engBusy = 1'b0;
            end
        end else if (engBusy && engCnt != '0) begin
            next_engCnt = engCnt - 1'b1;
        end
        // A job on the prefetched word's module makes that word stale
        if (peReq && !refuse && peModule == next_pfAddr[MSB]) begin
            next_pfValid = 1'b0;
        end
        if (accept) begin
            // All processor reads enter through this one arbitrated port
            next_activeModule = reqAddr[MSB];
            next_activeValid = 1'b1;
            if (pfValid && reqAddr == pfAddr) begin
                // Sequential hit skips the wait states
                next_rdValid = 1'b1;
                next_rdData = pfData;
                next_pfValid = 1'b0;
                next_engAddr = pfAddr + 1'b1;
                next_engCnt = waitStates;
                next_engBusy = 1'b1;
                next_demand = 1'b0;
                startFetch = 1'b1;
            end else if (engDone && !demand && reqAddr == engAddr) begin
                next_rdValid = 1'b1;
                next_rdData = readData;
                next_pfValid = 1'b0;
                next_engAddr = engAddr + 1'b1;
                next_engCnt = waitStates;
                next_engBusy = 1'b1;
                startFetch = 1'b1;
            end else if (engBusy && !demand && reqAddr == engAddr) begin
                next_demand = 1'b1;
            end else begin
                // Non-sequential access pays the full wait states
                next_engAddr = reqAddr;
                next_engCnt = waitStates;
                next_engBusy = 1'b1;
                next_demand = 1'b1;
                next_pfValid = 1'b0;
                startFetch = 1'b1;
            end
        end
        next_fetchReady = !next_demand;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            engAddr <= '0;
            engCnt <= '0;
            engBusy <= 1'b0;
            demand <= 1'b0;
            pfValid <= 1'b0;
            pfAddr <= '0;
            pfData <= '0;
            activeModule <= 1'b0;
            activeValid <= 1'b0;
            waitStates <= WS_RESET;
            fetchReady <= 1'b1;
            rdValid <= 1'b0;
            rdData <= '0;
            peError <= 1'b0;
        end else if (clkEn) begin
            engAddr <= next_engAddr;
            engCnt <= next_engCnt;
            engBusy <= next_engBusy;
            demand <= next_demand;
            pfValid <= next_pfValid;
            pfAddr <= next_pfAddr;
            pfData <= next_pfData;
            activeModule <= next_activeModule;
            activeValid <= next_activeValid;
            waitStates <= next_waitStates;
            fetchReady <= next_fetchReady;
            rdValid <= next_rdValid;
            rdData <= next_rdData;
            peError <= next_peError;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clkEn && loadEn) begin
            pageBuf[loadIdx] <= loadData;
        end
    end

    // Refuse a job on the module being read or on a module already busy
    always_comb begin
        refuse = (peModule == activeModule && readingFlash) || peActive[peModule];
        next_peError = peReq && refuse;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_MODULES; gi++) begin : g_mod
            dfac_pe_state_t state, next_state;
            logic [CNT_W-1:0] cnt, next_cnt;
            logic op, next_op;
            logic [PAGE_NUM_W-1:0] page, next_page;
            logic [PAGE_IDX_W-1:0] wIdx, next_wIdx;
            logic busyQ, doneQ, next_done;
            logic start, wrEn, markEn, eraseEn;
            int unsigned age;

            // Other modules keep serving reads while this one works
            assign start = peReq && !refuse && peModule == 1'(gi);
            assign wrEn = state == PE_COMMIT;
            assign markEn = wrEn && wIdx == PAGE_IDX_W'(PAGE_WORDS - 1);
            assign eraseEn = state == PE_TIMED && cnt == '0 && op == OP_ERASE;
            assign peActive[gi] = state != PE_IDLE;
            assign peBusy[gi] = busyQ;
            assign peDone[gi] = doneQ;

            always_comb begin
                next_state = state;
                next_cnt = cnt;
                next_op = op;
                next_page = page;
                next_wIdx = wIdx;
                next_done = 1'b0;
                case (state)
                    PE_IDLE: begin
                        if (start) begin
                            next_op = peOp;
                            next_page = pePage;
                            next_cnt = CNT_W'(OVERHEAD_CYCLES - 1);
                            next_state = PE_SETUP;
                        end
                    end
                    PE_SETUP: begin
                        if (cnt == '0) begin
                            next_cnt = (op == OP_PROGRAM) ? CNT_W'(PROG_CYCLES - 1) : CNT_W'(ERASE_CYCLES - 1);
                            next_state = PE_TIMED;
                        end else begin
                            next_cnt = cnt - 1'b1;
                        end
                    end
                    PE_TIMED: begin
                        if (cnt != '0) begin
                            next_cnt = cnt - 1'b1;
                        end else if (op == OP_ERASE) begin
                            next_done = 1'b1;
                            next_state = PE_IDLE;
                        end else begin
                            next_wIdx = '0;
                            next_state = PE_COMMIT;
                        end
                    end
                    PE_COMMIT: begin
                        next_wIdx = wIdx + 1'b1;
                        if (markEn) begin
                            next_done = 1'b1;
                            next_state = PE_IDLE;
                        end
                    end
                    default: begin
                        next_state = PE_IDLE;
                    end
                endcase
            end

            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    state <= PE_IDLE;
                    cnt <= '0;
                    op <= OP_ERASE;
                    page <= '0;
                    wIdx <= '0;
                    busyQ <= 1'b0;
                    doneQ <= 1'b0;
                end else if (clkEn) begin
                    state <= next_state;
                    cnt <= next_cnt;
                    op <= next_op;
                    page <= next_page;
                    wIdx <= next_wIdx;
                    busyQ <= next_state != PE_IDLE;
                    doneQ <= next_done;
                end
            end

            dfac_flash_bank u_bank (
                .core_clk(core_clk),
                .rst(rst),
                .clkEn(clkEn),
                .rdAddr(engAddr[BANK_ADDR_W-1:0]),
                .rdData(bankRd[gi]),
                .wrEn(wrEn && clkEn),
                .wrAddr({page, wIdx}),
                .wrData(pageBuf[wIdx]),
                .markEn(markEn && clkEn),
                .eraseEn(eraseEn && clkEn),
                .opPage(page)
            );

            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    age <= 0;
                end else if (clkEn) begin
                    age <= (state == PE_IDLE) ? 0 : age + 1;
                end
            end

            a_erase_time: assert property (@(posedge core_clk) disable iff (rst)
                doneQ && op == OP_ERASE |-> age == OVERHEAD_CYCLES + ERASE_CYCLES)
                else $error("Erase took the wrong number of cycles");
            a_prog_time: assert property (@(posedge core_clk) disable iff (rst)
                doneQ && op == OP_PROGRAM |-> age == OVERHEAD_CYCLES + PROG_CYCLES + PAGE_WORDS)
                else $error("Program took the wrong number of cycles");
            a_no_busy_read: assert property (@(posedge core_clk) disable iff (rst)
                clkEn && engDone |-> !(state != PE_IDLE && engAddr[MSB] == 1'(gi)))
                else $error("Read served from a module under erase or program");
        end
    endgenerate

    // Cycles since the engine last started a fetch
    int unsigned fetchAge;
    logic [WS_W-1:0] fetchWs;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fetchAge <= 0;
            fetchWs <= '0;
        end else if (clkEn) begin
            fetchAge <= startFetch ? 0 : fetchAge + 1;
            fetchWs <= startFetch ? waitStates : fetchWs;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_ws_reset: assert property ($past(rst) && !rst |-> waitStates == WS_RESET)
        else $error("Wait states not at reset value");
    a_ws_load: assert property (clkEn && wsLoad |=> waitStates == $past(wsIn))
        else $error("Wait-state load lost");
    a_miss_wait: assert property (rdValid && $past(demand) |-> $past(fetchAge) >= 32'($past(fetchWs)))
        else $error("Non-sequential read answered before its wait states");
    a_hit_fast: assert property (clkEn && accept && pfValid && reqAddr == pfAddr |=> rdValid && rdData == $past(pfData))
        else $error("Prefetched word not delivered next cycle");
    a_refuse_active: assert property (clkEn && peReq && peModule == activeModule && readingFlash
        |=> peError && !$rose(peBusy[0]) && !$rose(peBusy[1]))
        else $error("Job on the read module not refused");
    a_single_port: assert property (rdValid |-> $past(demand) || $past(accept))
        else $error("Read answer without an accepted request");
    a_parallel_ok: assert property (clkEn && peReq && peModule && !peActive[1] && activeModule == 1'b0
        |=> !peError)
        else $error("Module 1 job refused while module 0 is read");

    c_seq_hit: cover property (accept && pfValid && reqAddr == pfAddr);
    c_read_during_pe: cover property (rdValid && peBusy[1] && activeModule == 1'b0);
    c_refused: cover property (peError);
    c_erase_done: cover property (peDone[0]);
endmodule

// ### dfac_pkg.sv
package dfac_pkg;
    localparam int NUM_MODULES = 2;
    localparam int DATA_W = 32;
    localparam int BANK_ADDR_W = 8;
    localparam int FETCH_ADDR_W = BANK_ADDR_W + 1;
    localparam int PAGE_IDX_W = 4;
    localparam int PAGE_WORDS = 1 << PAGE_IDX_W;
    localparam int PAGE_NUM_W = BANK_ADDR_W - PAGE_IDX_W;
    localparam int WS_W = 3;
    localparam logic [WS_W-1:0] WS_RESET = 3'h4;
    localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
    localparam logic OP_ERASE = 1'b0;
    localparam logic OP_PROGRAM = 1'b1;
    localparam int CLK_PERIOD_NS = 100;
    localparam real ERASE_TIME_MS = 8.0;
    localparam real PROG_TIME_MS = 3.5;
    localparam int ERASE_CYCLES = int'($floor(ERASE_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int PROG_CYCLES = int'($floor(PROG_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int OVERHEAD_CYCLES = 4;

    typedef enum logic [1:0] {PE_IDLE, PE_SETUP, PE_TIMED, PE_COMMIT} dfac_pe_state_t;
endpackage

// ### dual_flash_access_control_tb.sv
`timescale 1ns/1ps
module dual_flash_access_control_tb;
    import dfac_pkg::*;
    localparam int ERASE_N = 20;
    localparam int PROG_N = 10;
    logic core_clk, rst, clkEn, wsLoad, fetchReq, execFromSram, fetchReady, rdValid, loadEn, peReq, peModule;
    logic peOp, peError;
    logic [WS_W-1:0] wsIn, waitStates;
    logic [FETCH_ADDR_W-1:0] reqAddr;
    logic [DATA_W-1:0] rdData, loadData;
    logic [PAGE_IDX_W-1:0] loadIdx;
    logic [PAGE_NUM_W-1:0] pePage, pg;
    logic [NUM_MODULES-1:0] peBusy, peDone;
    logic [DATA_W-1:0] mem [512];
    logic [DATA_W-1:0] pbuf [16];
    logic [DATA_W-1:0] expQ [$];
    logic [7:0] a;
    int errCount, numChecks, cycles, curWs;

    dfac_flash_ctrl #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) DUT (.core_clk(core_clk), .rst(rst),
        .clkEn(clkEn), .wsLoad(wsLoad), .wsIn(wsIn), .waitStates(waitStates), .fetchReq(fetchReq),
        .reqAddr(reqAddr), .execFromSram(execFromSram), .fetchReady(fetchReady), .rdValid(rdValid),
        .rdData(rdData), .loadEn(loadEn), .loadIdx(loadIdx), .loadData(loadData), .peReq(peReq),
        .peModule(peModule), .peOp(peOp), .pePage(pePage), .peBusy(peBusy), .peDone(peDone), .peError(peError));
    dfac_core_model core (.core_clk(core_clk), .wsLoad(wsLoad), .wsIn(wsIn), .fetchReady(fetchReady),
        .rdValid(rdValid), .fetchReq(fetchReq), .reqAddr(reqAddr));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic summarize();
        if (errCount == 0 && numChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Notes the expected word, fetches it, and checks latency when one is given
    task automatic readAt(input logic [FETCH_ADDR_W-1:0] addr, input int expLat);
        int lat;
        expQ.push_back(mem[addr]);
        core.fetch(addr, lat);
        if (expLat > 0) begin
            checkWord("fetch latency", expLat, lat);
        end
    endtask

    task automatic loadPage();
        for (int i = 0; i < 16; i++) begin
            @(negedge core_clk);
            pbuf[i] = $urandom;
            loadEn = 1'b1;
            loadIdx = i[3:0];
            loadData = pbuf[i];
        end
        @(negedge core_clk);
        loadEn = 1'b0;
    endtask

    // Issues one erase or program job and follows it to its end or refusal
    task automatic peJob(input logic m, input logic op, input logic [PAGE_NUM_W-1:0] p, input logic refuse);
        int n;
        @(negedge core_clk);
        peReq = 1'b1;
        peModule = m;
        peOp = op;
        pePage = p;
        @(negedge core_clk);
        peReq = 1'b0;
        if (refuse) begin
            checkWord("refusal flag", 32'h1, {31'h0, peError});
            return;
        end
        for (int i = 0; i < 16; i++) begin
            mem[{m, p, i[3:0]}] = op ? pbuf[i] : ERASED_WORD;
        end
        n = 1;
        checkWord("job busy", 32'h1, {31'h0, peBusy[m]});
        while (peDone[m] !== 1'b1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        checkWord("job end cycle", op ? OVERHEAD_CYCLES + PROG_N + PAGE_WORDS + 1 : OVERHEAD_CYCLES + ERASE_N + 1, n);
        checkWord("job busy end", 32'h0, {31'h0, peBusy[m]});
    endtask

    // Compares every answer with the oldest noted word
    always @(negedge core_clk) begin
        if (rdValid === 1'b1) begin
            checkWord("read data", expQ.size() > 0 ? expQ.pop_front() : 32'hX, rdData);
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 6000) begin
            errCount++;
            summarize();
        end
    end

    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        execFromSram = 1'b0;
        loadEn = 1'b0;
        loadIdx = 4'h0;
        loadData = 32'h0;
        peReq = 1'b0;
        peModule = 1'b0;
        peOp = OP_ERASE;
        pePage = 4'h0;
        for (int i = 0; i < 512; i++) begin
            mem[i] = ERASED_WORD;
        end
        void'($urandom(32'hD936DAFF));
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        checkWord("wait states after reset", {29'h0, WS_RESET}, {29'h0, waitStates});
        checkWord("busy after reset", 32'h0, {30'h0, peBusy});
        // Miss then sequential hit at each setting from 4 down to 2
        for (int w = 4; w >= 2; w--) begin
            core.setWs(w[2:0]);
            curWs = w;
            checkWord("wait states loaded", w, {29'h0, waitStates});
            // Disjoint ranges keep each miss away from the word still prefetched
            a = 8'($urandom_range(0, 60) + (w - 2) * 64);
            readAt({1'b0, a}, curWs + 2);
            repeat (12) @(negedge core_clk);
            readAt({1'b0, a + 8'h1}, 1);
        end
        // Program module 1 while module 0 keeps delivering
        loadPage();
        pg = PAGE_NUM_W'($urandom_range(0, 15));
        fork
            peJob(1'b1, OP_PROGRAM, pg, 1'b0);
            begin
                repeat (3) @(negedge core_clk);
                a = 8'($urandom_range(100, 200));
                readAt({1'b0, a}, curWs + 2);
            end
        join
        for (int i = 0; i < 16; i++) begin
            readAt({1'b1, pg, i[3:0]}, 0);
        end
        // Module 1 is now being read, so erasing it is refused
        peJob(1'b1, OP_ERASE, pg, 1'b1);
        readAt({1'b1, pg, 4'h5}, 0);
        // Code from program SRAM: both modules may run, a busy module refuses
        execFromSram = 1'b1;
        fork
            peJob(1'b0, OP_ERASE, 4'h0, 1'b0);
            begin
                repeat (2) @(negedge core_clk);
                peJob(1'b1, OP_ERASE, pg, 1'b0);
            end
            begin
                repeat (6) @(negedge core_clk);
                peJob(1'b1, OP_PROGRAM, pg, 1'b1);
            end
        join
        execFromSram = 1'b0;
        readAt({1'b1, pg, 4'h3}, 0);
        readAt({1'b0, 8'h7}, 0);
        repeat (10) @(negedge core_clk);
        // A load while the clock enable is low must not take
        clkEn = 1'b0;
        core.setWs(3'h3);
        checkWord("frozen wait states", 32'h2, {29'h0, waitStates});
        clkEn = 1'b1;
        checkWord("answers pending", 32'h0, expQ.size());
        summarize();
    end
endmodule
